/* hdl/usb_accessory_switch_regs.v */
// Purpose: control and status registers of the accessory switch section
// Assumes: host port gives address, write strobe, read strobe and data in one cycle
// Notes:   read data is registered and appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "usb_accessory_switch_consts.vh"

// Overview of operation
// - connect bit zero opens every switch except the teletype left speaker route and the onthego supply switch
// - soft reset pulses, sets flag, self clears
// - teletype bit closes left speaker switch
// - bit 7 shows active or standby
// - onthego enable, cleared by general reset
// - hold bit halts detection until cleared
// - bus voltage code 10 routes to microphone
// - positive field selects usb, speaker, uart
// - negative field same encoding, else open
// - accessory flags bits 0-17, read only
// - id pin code in bits 23-19
// - spare registers read zero
// - manual bit picks manual or auto routing
module usb_accessory_switch_regs #(
   parameter ADDR_W = 6
) (
   input  wire              clock,
   input  wire              rst_n,
   input  wire              usb_block_reset_n,
   input  wire              general_reset_n,
   input  wire [ADDR_W-1:0] regAddr,
   input  wire              regWrite,
   input  wire              regRead,
   input  wire [23:0]       regWdata,
   input  wire              deviceActive,
   input  wire [17:0]       accessoryFlags,
   input  wire [4:0]        id_pin_resistance_code,
   input  wire              autoToUsb,
   input  wire              autoToSpeaker,
   input  wire              autoToUart,
   input  wire              autoBusToMic,
   output reg  [23:0]       regRdata,
   output reg               read_result_valid,
   output reg               softResetOut,
   output reg               detection_hold,
   output reg               onthego_supply_switch_en,
   output reg               teletype_left_speaker_route,
   output reg               busToMicrophone,
   output reg               posToUsb,
   output reg               posToSpeaker,
   output reg               posToUart,
   output reg               negToUsb,
   output reg               negToSpeaker,
   output reg               negToUart
);
   localparam SR_IDLE  = 2'h0;
   localparam SR_ARMED = 2'h1;
   localparam SR_PULSE = 2'h2;

   reg        waitBit_r;
   reg        manualAuto_r;
   reg        rawData_r;
   reg        switchConnect_r;
   reg  [1:0] softState_r;
   reg  [1:0] softState_nxt;
   reg        resetOccurred_r;
   reg [1:0]  bus_voltage_route_sel;
   reg [2:0]  positive_line_route_sel;
   reg [2:0]  negative_line_route_sel;
   reg [3:0]  softCnt_r;
   reg [3:0]  softCnt_nxt;
   reg [17:0] accFlags_r;
   reg [4:0]  idCode_r;
   reg        activeSync_r;
   wire       usbRst_n;
   wire       ctlWrite;
   wire       ctlRead;
   wire       pU;
   wire       pS;
   wire       pR;
   wire       nU;
   wire       nS;
   wire       nR;
   reg  [23:0] rdMux;
   reg         busMic_nxt;
   reg  [2:0]  posRoute_nxt;
   reg  [2:0]  negRoute_nxt;
   wire        softDone;

   // register index decode shared by the write and read strobes
   function is_control;
      input [ADDR_W-1:0] addr;
      begin
         is_control = (addr == `ADDR_USB_SWITCH_CONTROL);
      end
   endfunction

   // master reset also clears the usb-block fields
   assign usbRst_n = rst_n & usb_block_reset_n;
   assign ctlWrite = regWrite && is_control(regAddr);
   assign ctlRead  = regRead && is_control(regAddr);
   // the last pulse cycle ends the sequence and marks the reset flag
   assign softDone = (softState_r == SR_PULSE) && (softCnt_r == `SOFT_RESET_CYCLES);

   line_route_decode uPos (
      .sel       (positive_line_route_sel),
      .toUsb     (pU),
      .toSpeaker (pS),
      .toUart    (pR)
   );
   line_route_decode uNeg (
      .sel       (negative_line_route_sel),
      .toUsb     (nU),
      .toSpeaker (nS),
      .toUart    (nR)
   );

   always @(posedge clock or negedge usbRst_n) begin
      if (!usbRst_n) begin
         waitBit_r               <= 1'b1;
         manualAuto_r            <= `RST_MANUAL_AUTO;
         rawData_r               <= 1'b1;
         switchConnect_r         <= `RST_SWITCH_CONNECT;
         teletype_left_speaker_route <= 1'b0;
         detection_hold          <= `RST_DETECTION_HOLD;
         bus_voltage_route_sel   <= 2'h0;
         positive_line_route_sel <= 3'h0;
         negative_line_route_sel <= 3'h0;
      end else if (ctlWrite) begin
         waitBit_r               <= regWdata[0];
         manualAuto_r            <= regWdata[`BIT_MANUAL_AUTO];
         rawData_r               <= regWdata[2];
         switchConnect_r         <= regWdata[`BIT_SWITCH_CONNECT];
         teletype_left_speaker_route <= regWdata[`BIT_TELETYPE_LEFT_SPEAKER_ROUTE];
         detection_hold          <= regWdata[`BIT_DETECTION_HOLD];
         bus_voltage_route_sel   <= regWdata[`BUS_V_LSB +: 2];
         positive_line_route_sel <= regWdata[`POS_LINE_LSB +: 3];
         negative_line_route_sel <= regWdata[`NEG_LINE_LSB +: 3];
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         onthego_supply_switch_en <= 1'b0;
      end else if (!general_reset_n) begin
         onthego_supply_switch_en <= 1'b0;
      end else if (ctlWrite) begin
         onthego_supply_switch_en <= regWdata[`BIT_ONTHEGO];
      end
   end

   // soft reset sequencer; kept on rst_n so it survives its own pulse
   always @* begin
      softState_nxt = softState_r;
      softCnt_nxt   = softCnt_r;
      case (softState_r)
         SR_IDLE: begin
            softCnt_nxt = 4'h0;
            if (ctlWrite && regWdata[`BIT_SOFT_RESET]) begin
               softState_nxt = SR_ARMED;
            end
         end
         SR_ARMED: begin
            softState_nxt = SR_PULSE;
            softCnt_nxt   = 4'h1;
         end
         SR_PULSE: begin
            softCnt_nxt = softCnt_r + 4'h1;
            if (softDone) begin
               softState_nxt = SR_IDLE;
               softCnt_nxt   = 4'h0;
            end
         end
         default: begin
            softState_nxt = SR_IDLE;
            softCnt_nxt   = 4'h0;
         end
      endcase
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         softState_r  <= SR_IDLE;
         softCnt_r    <= 4'h0;
         softResetOut <= 1'b0;
      end else begin
         softState_r  <= softState_nxt;
         softCnt_r    <= softCnt_nxt;
         softResetOut <= (softState_nxt == SR_PULSE);
      end
   end

   // reset flag: set wins over read clear
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         resetOccurred_r <= 1'b1;
      end else if (!usb_block_reset_n || softDone) begin
         resetOccurred_r <= 1'b1;
      end else if (ctlRead) begin
         resetOccurred_r <= 1'b0;
      end
   end

   always @(posedge clock or negedge usbRst_n) begin
      if (!usbRst_n) begin
         accFlags_r   <= 18'h0;
         idCode_r     <= 5'h0;
         activeSync_r <= 1'b0;
      end else begin
         accFlags_r   <= accessoryFlags;
         idCode_r     <= id_pin_resistance_code;
         activeSync_r <= deviceActive;
      end
   end

   always @* begin
      rdMux = 24'h0;
      case (regAddr)
         `ADDR_USB_SWITCH_CONTROL: begin
            rdMux[0]                  = waitBit_r;
            rdMux[`BIT_MANUAL_AUTO]   = manualAuto_r;
            rdMux[2]                  = rawData_r;
            rdMux[`BIT_SWITCH_CONNECT] = switchConnect_r;
            rdMux[`BIT_SOFT_RESET]    = (softState_r != SR_IDLE);
            rdMux[`BIT_TELETYPE_LEFT_SPEAKER_ROUTE]      = teletype_left_speaker_route;
            rdMux[`BIT_RESET_OCCURRED] = resetOccurred_r;
            rdMux[`BIT_ACTIVE]        = activeSync_r;
            rdMux[8]                  = 1'b1;
            rdMux[`BIT_ONTHEGO]       = onthego_supply_switch_en;
            rdMux[`BIT_DETECTION_HOLD] = detection_hold;
            rdMux[`BUS_V_LSB +: 2]    = bus_voltage_route_sel;
            rdMux[`POS_LINE_LSB +: 3] = positive_line_route_sel;
            rdMux[`NEG_LINE_LSB +: 3] = negative_line_route_sel;
            rdMux[23]                 = read_result_valid;
         end
         `ADDR_ATTACHED_ACC_TYPE: begin
            rdMux[17:0]               = accFlags_r;
            rdMux[`ID_CODE_LSB +: 5]  = idCode_r;
         end
         default: begin
            rdMux = 24'h0;
         end
      endcase
   end

   always @(posedge clock or negedge usbRst_n) begin
      if (!usbRst_n) begin
         regRdata          <= 24'h0;
         read_result_valid <= 1'b0;
      end else begin
         read_result_valid <= regRead;
         if (regRead) begin
            regRdata <= rdMux;
         end
      end
   end

   always @* begin
      busMic_nxt   = 1'b0;
      posRoute_nxt = 3'h0;
      negRoute_nxt = 3'h0;
      if (!switchConnect_r) begin
         busMic_nxt   = 1'b0;
         posRoute_nxt = 3'h0;
         negRoute_nxt = 3'h0;
      end else if (manualAuto_r) begin
         // auto mode drives both data pins from the detected pair
         busMic_nxt   = autoBusToMic;
         posRoute_nxt = {autoToUart, autoToSpeaker, autoToUsb};
         negRoute_nxt = {autoToUart, autoToSpeaker, autoToUsb};
      end else begin
         busMic_nxt   = (bus_voltage_route_sel == `BUSV_TO_MIC);
         posRoute_nxt = {pR, pS, pU};
         negRoute_nxt = {nR, nS, nU};
      end
   end

   // registered closures keep the pins glitch free
   always @(posedge clock or negedge usbRst_n) begin
      if (!usbRst_n) begin
         busToMicrophone <= 1'b0;
         posToUsb        <= 1'b0;
         posToSpeaker    <= 1'b0;
         posToUart       <= 1'b0;
         negToUsb        <= 1'b0;
         negToSpeaker    <= 1'b0;
         negToUart       <= 1'b0;
      end else begin
         busToMicrophone <= busMic_nxt;
         posToUsb        <= posRoute_nxt[0];
         posToSpeaker    <= posRoute_nxt[1];
         posToUart       <= posRoute_nxt[2];
         negToUsb        <= negRoute_nxt[0];
         negToSpeaker    <= negRoute_nxt[1];
         negToUart       <= negRoute_nxt[2];
      end
   end
endmodule
`default_nettype wire

/* hdl/usb_accessory_switch_consts.vh */
// Purpose: constants for the accessory switch register bank
// Assumes: 24-bit registers on a word-addressed serial register port
// Notes:   offsets are register indices as seen by the host
`ifndef USB_ACCESSORY_SWITCH_CONSTS_VH
`define USB_ACCESSORY_SWITCH_CONSTS_VH

`define ADDR_USB_SWITCH_CONTROL   6'h27
`define ADDR_ATTACHED_ACC_TYPE    6'h28
`define ADDR_SPARE_REGISTER_A     6'h29
`define ADDR_SPARE_REGISTER_B     6'h2a

`define BIT_MANUAL_AUTO           1
`define BIT_SWITCH_CONNECT        3
`define BIT_SOFT_RESET            4
`define BIT_TELETYPE_LEFT_SPEAKER_ROUTE              5
`define BIT_RESET_OCCURRED        6
`define BIT_ACTIVE                7
`define BIT_ONTHEGO               9
`define BIT_DETECTION_HOLD        12
`define BUS_V_LSB                 15
`define POS_LINE_LSB              17
`define NEG_LINE_LSB              20
`define BIT_UNRECOGNISED          17
`define ID_CODE_LSB               19

`define RST_SWITCH_CONNECT        1'h1
`define RST_DETECTION_HOLD        1'h1
`define RST_MANUAL_AUTO           1'h1

`define BUSV_TO_MIC               2'h2
`define LINE_OPEN                 3'h0
`define LINE_USB                  3'h1
`define LINE_SPEAKER              3'h2
`define LINE_UART                 3'h3

`define SOFT_RESET_CYCLES         4'h4

`endif

/* hdl/line_route_decode.v */
// Purpose: decode one data-line routing field into switch closures
// Assumes: combinational, used for positive and negative line fields
// Notes:   unknown codes open every switch of the line
`timescale 1ns/1ps
`default_nettype none
`include "usb_accessory_switch_consts.vh"
module line_route_decode (
   input  wire [2:0] sel,
   output reg        toUsb,
   output reg        toSpeaker,
   output reg        toUart
);
   always @* begin
      toUsb     = 1'b0;
      toSpeaker = 1'b0;
      toUart    = 1'b0;
      case (sel)
         `LINE_USB: begin
            toUsb = 1'b1;
         end
         `LINE_SPEAKER: begin
            toSpeaker = 1'b1;
         end
         `LINE_UART: begin
            toUart = 1'b1;
         end
         default: begin
            toUsb = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* tb/usb_accessory_switch_regs_asserts.sv */
// Purpose: port assertions for the accessory switch registers
// Assumes: one clock domain, rst_n asynchronous
// Notes:   switch outputs settle two cycles after a write
`timescale 1ns/1ps
`default_nettype none
module usb_accessory_switch_regs_asserts (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        usb_block_reset_n,
   input wire logic        general_reset_n,
   input wire logic [5:0]  regAddr,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [23:0] regWdata,
   input wire logic [17:0] accessoryFlags,
   input wire logic [4:0]  id_pin_resistance_code,
   input wire logic [23:0] regRdata,
   input wire logic        read_result_valid,
   input wire logic        softResetOut,
   input wire logic        onthego_supply_switch_en,
   input wire logic        busToMicrophone,
   input wire logic        posToUsb,
   input wire logic        posToSpeaker,
   input wire logic        posToUart,
   input wire logic        negToUsb,
   input wire logic        negToSpeaker,
   input wire logic        negToUart
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // manual routing with switches connected
   wire logic ctlWr = regWrite && regAddr == 6'h27 && usb_block_reset_n && regWdata[3] && !regWdata[1];
   wire logic anyClosed = posToUsb || posToSpeaker || posToUart || negToUsb || negToSpeaker || negToUart;

   a_read_valid: assert property (regRead |=> read_result_valid)
      else $error("no valid pulse after read");
   a_soft_length: assert property ($rose(softResetOut) |-> softResetOut [*4] ##1 !softResetOut)
      else $error("soft reset pulse length wrong");
   a_soft_cause: assert property ($rose(softResetOut) |-> $past(regWrite, 2) && $past(regWdata[4], 2))
      else $error("soft reset without request");
   a_pos_usb: assert property (ctlWr && regWdata[19:17] == 3'h1 |-> ##2 posToUsb && !posToSpeaker && !posToUart)
      else $error("positive line not on usb");
   a_neg_speaker: assert property (ctlWr && regWdata[22:20] == 3'h2 |-> ##2 negToSpeaker && !negToUsb && !negToUart)
      else $error("negative line not on speaker");
   a_neg_open: assert property (ctlWr && regWdata[22:20] > 3'h3 |-> ##2 !(negToUsb || negToSpeaker || negToUart))
      else $error("negative line closed on open code");
   a_bus_mic: assert property (ctlWr |-> ##2 busToMicrophone == ($past(regWdata[16:15], 2) == 2'h2))
      else $error("bus voltage routing wrong");
   a_open_all: assert property (regWrite && regAddr == 6'h27 && usb_block_reset_n && !regWdata[3]
      |-> ##2 !(anyClosed || busToMicrophone))
      else $error("switch closed while disconnected");
   a_flags_read: assert property (regRead && regAddr == 6'h28
      |=> regRdata == {$past(id_pin_resistance_code, 2), 1'b0, $past(accessoryFlags, 2)})
      else $error("accessory type read wrong");
   a_spare_zero: assert property (regRead && (regAddr == 6'h29 || regAddr == 6'h2a) |=> regRdata == 24'h0)
      else $error("spare register not zero");
   a_otg_clear: assert property (!general_reset_n |=> !onthego_supply_switch_en)
      else $error("onthego enable survived reset");
endmodule
bind usb_accessory_switch_regs usb_accessory_switch_regs_asserts chk (.*);
`default_nettype wire

/* tb/usb_accessory_host.sv */
// Purpose: host side of the register port
// Assumes: one access per call, strobe held for one taken edge
// Notes:   write data shows the inverted value when idle
`timescale 1ns/1ps
`default_nettype none
module usb_accessory_host (
   input  wire logic        clock,
   input  wire logic [23:0] regRdata,
   input  wire logic        read_result_valid,
   output var  logic [5:0]  regAddr,
   output var  logic        regWrite,
   output var  logic        regRead,
   output var  logic [23:0] regWdata
);
   initial begin
      regAddr = 6'h3f;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWdata = 24'h0;
   end
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(posedge clock);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      regWdata <= ~d;
   endtask
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      // answer launched at the taking edge, settled by the falling edge
      @(negedge clock);
      d = regRdata;
      v = read_result_valid;
      @(posedge clock);
   endtask
endmodule
`default_nettype wire

/* tb/usb_accessory_switch_regs_tb.sv */
// Purpose: self-checking bench for the accessory switch registers
// Assumes: host model drives the register port
// Notes:   auto routing inputs are held constant
`timescale 1ns/1ps
`default_nettype none
module usb_accessory_switch_regs_tb;
   logic clock = 1'b0, rst_n = 1'b0, usb_block_reset_n = 1'b1, general_reset_n = 1'b1;
   logic deviceActive = 1'b0, autoToUsb = 1'b1, autoToSpeaker = 1'b0, autoToUart = 1'b0, autoBusToMic = 1'b0;
   logic [17:0] accessoryFlags = 18'h2a5c3;
   logic [4:0]  id_pin_resistance_code = 5'h16;
   wire logic [5:0] regAddr;
   wire logic [23:0] regWdata, regRdata;
   wire logic regWrite, regRead, read_result_valid, softResetOut, detection_hold, onthego_supply_switch_en;
   wire logic teletype_left_speaker_route, busToMicrophone, posToUsb, posToSpeaker, posToUart;
   wire logic negToUsb, negToSpeaker, negToUart;
   int failures = 0, check_count = 0;
   logic [23:0] rv;
   logic vv;
   always #25 clock = ~clock;
   usb_accessory_switch_regs uut (.*);
   usb_accessory_host host (.*);
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [5:0] a, input logic [23:0] m, input logic [23:0] e);
      host.rd(a, rv, vv);
      chk({23'h0, vv}, 24'h1);
      chk(rv & m, e);
   endtask
   task automatic settle;
      repeat (2) @(posedge clock);
      #1;
   endtask
   task t_reset;
      rchk(6'h27, 24'h7fff7a, 24'h00114a);
      chk({22'h0, detection_hold, teletype_left_speaker_route}, 24'h2);
      rchk(6'h27, 24'h000040, 24'h0);
   endtask
   task t_access;
      @(posedge clock);
      deviceActive <= 1'b1;
      rchk(6'h27, 24'h000080, 24'h80);
      deviceActive <= 1'b0;
      host.wr(6'h27, 24'hffffef);
      rchk(6'h27, 24'h7ffffa, 24'h7f932a);
      chk({23'h0, teletype_left_speaker_route}, 24'h1);
      host.wr(6'h28, 24'hffffff);
      rchk(6'h28, 24'hffffff, {id_pin_resistance_code, 1'b0, accessoryFlags});
      host.wr(6'h29, 24'hffffff);
      rchk(6'h29, 24'hffffff, 24'h0);
      rchk(6'h2a, 24'hffffff, 24'h0);
   endtask
   task t_routes;
      logic [2:0] e;
      for (int c = 0; c < 8; c++) begin
         // hold cleared so detection may run
         host.wr(6'h27, {1'b0, c[2:0], c[2:0], c[1:0], 15'h0008});
         settle;
         e = (c >= 1 && c <= 3) ? 3'h1 << (c - 1) : 3'h0;
         chk({21'h0, posToUart, posToSpeaker, posToUsb}, {21'h0, e});
         chk({21'h0, negToUart, negToSpeaker, negToUsb}, {21'h0, e});
         chk({23'h0, busToMicrophone}, {23'h0, c[1:0] == 2'h2});
      end
      host.wr(6'h27, 24'h120000);
      settle;
      chk({21'h0, posToUart, posToSpeaker, posToUsb}, 24'h0);
      host.wr(6'h27, 24'h00000a);
      settle;
      chk({22'h0, posToUsb, negToUsb}, 24'h3);
   endtask
   task t_soft;
      int n;
      n = 0;
      host.wr(6'h27, 24'h000018);
      repeat (10) begin
         @(posedge clock);
         #1;
         if (softResetOut === 1'b1)
            n++;
      end
      chk(n[23:0], 24'h4);
      rchk(6'h27, 24'h000050, 24'h40);
   endtask
   task t_resets;
      host.wr(6'h27, 24'h000208);
      settle;
      chk({23'h0, onthego_supply_switch_en}, 24'h1);
      @(posedge clock);
      general_reset_n <= 1'b0;
      @(posedge clock);
      general_reset_n <= 1'b1;
      usb_block_reset_n <= 1'b0;
      @(posedge clock);
      usb_block_reset_n <= 1'b1;
      settle;
      chk({22'h0, onthego_supply_switch_en, detection_hold}, 24'h1);
      rchk(6'h27, 24'h000040, 24'h000040);
   endtask
   task report_and_stop;
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_access;
      t_routes;
      t_soft;
      t_resets;
      report_and_stop;
   end
   // the whole sequence needs well under 400 cycles
   initial begin
      #(3000 * 50);
      failures++;
      report_and_stop;
   end
endmodule
`default_nettype wire
